//--- shared/cal_regs_pkg.sv
// package: command codes, field layouts, defaults and types for the calibration register bank
package cal_regs_pkg;
   // ---------------------------------------------------------------
   // command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_PHASE_SPREAD = 8'h37;
   localparam logic [7:0] CMD_SENSE_GAIN   = 8'h38;
   localparam logic [7:0] CMD_SENSE_OFFSET = 8'h39;
   localparam logic [7:0] CMD_OV_THRESHOLD = 8'h40;
   localparam logic [7:0] CMD_OV_REACTION  = 8'h41;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;

   // ---------------------------------------------------------------
   // fields and defaults
   // ---------------------------------------------------------------
   localparam int          COUNT_MSB        = 7;
   localparam int          COUNT_LSB        = 4;
   localparam int          POS_MSB          = 3;
   localparam int          POS_LSB          = 0;
   localparam int          EXP_MSB          = 15;
   localparam int          EXP_LSB          = 11;
   localparam int          MANT_MSB         = 10;
   localparam int          MANT_LSB         = 0;
   localparam logic [15:0] SENSE_GAIN_RST   = 16'hb2ae;
   localparam logic [15:0] SENSE_OFFSET_RST = 16'hbd00;
   localparam logic [7:0]  OV_REACTION_RST  = 8'h80;
   localparam logic [15:0] PHASE_USED_MASK  = 16'h00ff;
   localparam logic [4:0]  FIELD_ZERO_AS    = 5'h10;   // zero field reads as sixteen
   localparam logic [4:0]  SLOTS_PER_TURN   = 5'h10;   // 16 slots of 22.5 degrees
   localparam logic [4:0]  HALF_TURN_SLOTS  = 5'h08;   // 180 degrees
   // ov default = voltage_select_strap * 1.10, done as voltage_select_strap * 1126 / 1024
   localparam logic [10:0] OV_SCALE_NUM     = 11'h466;
   localparam int          OV_SCALE_SHIFT   = 10;

   // ---------------------------------------------------------------
   // carried groups
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] cmd;
      logic [15:0] wdata;
   } host_req_t;

   typedef struct packed {
      logic [15:0] rdata;
      logic        rvalid;
      logic        nack;
   } host_rsp_t;

   typedef struct packed {
      logic signed [4:0]  exponent;
      logic signed [10:0] mantissa;
   } lin11_t;
endpackage : cal_regs_pkg

//--- rtl/lin11_split.sv
// leaf: splits a linear-11 word into signed exponent and mantissa
`timescale 1ns/10ps
`default_nettype none
module lin11_split
(
   input  wire logic [15:0]          word,
   output var  cal_regs_pkg::lin11_t fields
);
   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   // top five bits exponent, low eleven mantissa, both two's complement
   assign fields.exponent = word[cal_regs_pkg::EXP_MSB:cal_regs_pkg::EXP_LSB];
   assign fields.mantissa = word[cal_regs_pkg::MANT_MSB:cal_regs_pkg::MANT_LSB];
endmodule // lin11_split
`default_nettype wire

//--- rtl/cal_regs.sv
// principal: phase spread, current sense calibration and overvoltage register bank
`timescale 1ns/10ps
`default_nettype none
module cal_regs
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    ce,
   input  wire cal_regs_pkg::host_req_t req,
   output var  cal_regs_pkg::host_rsp_t rsp,
   input  wire logic [15:0]             cfg_strap,
   input  wire logic [15:0]             voltage_select_strap,
   input  wire logic [15:0]             vout_code,
   input  wire logic                    share_auto_en,
   input  wire logic [4:0]              share_auto_slot,
   output logic [4:0]                   phase0_slot,
   output logic [4:0]                   phase1_slot,
   output logic                         alert_line_n,
   output logic                         ov_fault,
   output logic                         output_off,
   output var  cal_regs_pkg::lin11_t    gain_fields,
   output var  cal_regs_pkg::lin11_t    offset_fields
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  boot_cnt;
      logic [15:0] strap_cfg_s1;
      logic [15:0] strap_cfg_s2;
      logic [15:0] strap_v_s1;
      logic [15:0] strap_v_s2;
      logic [15:0] vout_s1;
      logic [15:0] vout_s2;
      logic        auto_s1;
      logic        auto_s2;
      logic [4:0]  slot_s1;
      logic [4:0]  slot_s2;
      logic [15:0] phase_spread_config;
      logic [15:0] current_sense_gain;
      logic [15:0] current_sense_offset;
      logic [15:0] overvoltage_threshold;
      logic [7:0]  overvoltage_reaction;
      logic        ov_fault;
      logic        output_off;
      logic [4:0]  phase0_slot;
      logic [4:0]  phase1_slot;
      logic        alert_n;
      cal_regs_pkg::host_rsp_t rsp;
   } state_t;

   state_t      st_r;
   state_t      st_nxt;
   logic [4:0]  count_dec;
   logic [4:0]  pos_dec;
   logic [8:0]  scaled;
   logic [4:0]  slot_raw;
   logic [4:0]  slot_wrap;
   logic [26:0] ov_prod;
   logic        ov_event;

   // ---------------------------------------------------------------
   // phase arithmetic
   // ---------------------------------------------------------------
   // zero fields stand for sixteen
   always_comb
   begin
      count_dec = {1'b0, st_r.phase_spread_config[cal_regs_pkg::COUNT_MSB:cal_regs_pkg::COUNT_LSB]};
      pos_dec   = {1'b0, st_r.phase_spread_config[cal_regs_pkg::POS_MSB:cal_regs_pkg::POS_LSB]};
      if (count_dec == 5'h00)
         count_dec = cal_regs_pkg::FIELD_ZERO_AS;
      if (pos_dec == 5'h00)
         pos_dec = cal_regs_pkg::FIELD_ZERO_AS;
      // round(pos*16/count): add half divisor before dividing
      scaled   = (9'({pos_dec, 4'h0}) + 9'(count_dec >> 1)) / 9'(count_dec);
      slot_raw = scaled[4:0];
      // a slot count of 16 or more is past a full turn; a position beyond its
      // group count can be several turns out, so every whole turn is dropped
      if (scaled >= 9'(cal_regs_pkg::SLOTS_PER_TURN))
         slot_wrap = {1'b0, scaled[3:0]};
      else
         slot_wrap = slot_raw;
   end

   lin11_split u_gain_split
   (
      .word   (st_r.current_sense_gain),
      .fields (gain_fields)
   );

   lin11_split u_offset_split
   (
      .word   (st_r.current_sense_offset),
      .fields (offset_fields)
   );

   // default threshold is 1.10 times the strap voltage
   assign ov_prod  = st_r.strap_v_s2 * cal_regs_pkg::OV_SCALE_NUM;
   assign ov_event = st_r.vout_s2 > st_r.overvoltage_threshold;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      // pins cross in through two stages
      st_nxt.strap_cfg_s1 = cfg_strap;
      st_nxt.strap_cfg_s2 = st_r.strap_cfg_s1;
      st_nxt.strap_v_s1   = voltage_select_strap;
      st_nxt.strap_v_s2   = st_r.strap_v_s1;
      st_nxt.vout_s1      = vout_code;
      st_nxt.vout_s2      = st_r.vout_s1;
      st_nxt.auto_s1      = share_auto_en;
      st_nxt.auto_s2      = st_r.auto_s1;
      st_nxt.slot_s1      = share_auto_slot;
      st_nxt.slot_s2      = st_r.slot_s1;
      st_nxt.rsp.rvalid   = 1'b0;
      st_nxt.rsp.nack     = 1'b0;
      // straps settle through the synchroniser before they are loaded once
      if (st_r.boot_cnt != 2'h3)
      begin
         st_nxt.boot_cnt = st_r.boot_cnt + 2'h1;
         if (st_r.boot_cnt == 2'h2)
         begin
            st_nxt.phase_spread_config   = st_r.strap_cfg_s2 & cal_regs_pkg::PHASE_USED_MASK;
            st_nxt.overvoltage_threshold = ov_prod[cal_regs_pkg::OV_SCALE_SHIFT +: 16];
         end
      end
      else
      begin
         // ov monitoring only after the defaults are in place
         if (ov_event)
         begin
            st_nxt.ov_fault   = 1'b1;
            // reaction 80h family: disable output, retry field 000 keeps it off
            if (st_r.overvoltage_reaction[7])
               st_nxt.output_off = 1'b1;
         end
         else if (req.wr && req.cmd == cal_regs_pkg::CMD_CLEAR_FAULTS)
            st_nxt.ov_fault = 1'b0;                                          // set wins over clear
         if (req.wr)
         begin
            case (req.cmd)
               cal_regs_pkg::CMD_PHASE_SPREAD:
                  st_nxt.phase_spread_config = req.wdata & cal_regs_pkg::PHASE_USED_MASK;
               cal_regs_pkg::CMD_SENSE_GAIN:   st_nxt.current_sense_gain    = req.wdata;
               cal_regs_pkg::CMD_SENSE_OFFSET: st_nxt.current_sense_offset  = req.wdata;
               cal_regs_pkg::CMD_OV_THRESHOLD: st_nxt.overvoltage_threshold = req.wdata;
               cal_regs_pkg::CMD_OV_REACTION:  st_nxt.overvoltage_reaction  = req.wdata[7:0];
               cal_regs_pkg::CMD_CLEAR_FAULTS: st_nxt.rsp.nack = 1'b0;
               default:                        st_nxt.rsp.nack = 1'b1;
            endcase
         end
         else if (req.rd)
         begin
            st_nxt.rsp.rvalid = 1'b1;
            case (req.cmd)
               cal_regs_pkg::CMD_PHASE_SPREAD: st_nxt.rsp.rdata = st_r.phase_spread_config;
               cal_regs_pkg::CMD_SENSE_GAIN:   st_nxt.rsp.rdata = st_r.current_sense_gain;
               cal_regs_pkg::CMD_SENSE_OFFSET: st_nxt.rsp.rdata = st_r.current_sense_offset;
               cal_regs_pkg::CMD_OV_THRESHOLD: st_nxt.rsp.rdata = st_r.overvoltage_threshold;
               cal_regs_pkg::CMD_OV_REACTION:  st_nxt.rsp.rdata = {8'h00, st_r.overvoltage_reaction};
               default:
               begin
                  st_nxt.rsp.rdata  = 16'h0000;
                  st_nxt.rsp.rvalid = 1'b0;
                  st_nxt.rsp.nack   = 1'b1;
               end
            endcase
         end
      end
      // phase placement, automatic inside a sharing group
      if (st_r.auto_s2)
         st_nxt.phase0_slot = {1'b0, st_r.slot_s2[3:0]};
      else
         st_nxt.phase0_slot = slot_wrap;
      st_nxt.phase1_slot = st_nxt.phase0_slot + cal_regs_pkg::HALF_TURN_SLOTS;
      if (st_nxt.phase1_slot >= cal_regs_pkg::SLOTS_PER_TURN)
         st_nxt.phase1_slot = st_nxt.phase1_slot - cal_regs_pkg::SLOTS_PER_TURN;
      // alert gets its own flop so the pin never sees a gate after the register
      st_nxt.alert_n = ~st_nxt.ov_fault;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_r                      <= '0;
         st_r.current_sense_gain   <= cal_regs_pkg::SENSE_GAIN_RST;
         st_r.current_sense_offset <= cal_regs_pkg::SENSE_OFFSET_RST;
         st_r.overvoltage_reaction <= cal_regs_pkg::OV_REACTION_RST;
         st_r.phase1_slot          <= cal_regs_pkg::HALF_TURN_SLOTS;
         st_r.alert_n              <= 1'b1;
      end
      else if (ce)
         st_r <= st_nxt;
   end

   assign rsp          = st_r.rsp;
   assign phase0_slot  = st_r.phase0_slot;
   assign phase1_slot  = st_r.phase1_slot;
   assign ov_fault     = st_r.ov_fault;
   assign alert_line_n = st_r.alert_n;
   assign output_off   = st_r.output_off;
endmodule // cal_regs
`default_nettype wire

//--- verif/cal_regs_properties.sv
// checker: answer timing, phase and sticky fault properties of the register bank
`timescale 1ns/10ps
`default_nettype none
module cal_regs_properties
(
   input wire logic                    clk,
   input wire logic                    rst,
   input wire logic                    ce,
   input wire cal_regs_pkg::host_req_t req,
   input wire cal_regs_pkg::host_rsp_t rsp,
   input wire logic [4:0]              phase0_slot,
   input wire logic [4:0]              phase1_slot,
   input wire logic                    alert_line_n,
   input wire logic                    ov_fault,
   input wire logic                    output_off,
   input wire cal_regs_pkg::lin11_t    gain_fields,
   input wire cal_regs_pkg::lin11_t    offset_fields
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [2:0] boot_r;
   // boot margin kept wide: requests are only judged well after strap load
   always_ff @(posedge clk)
   begin
      if (rst) boot_r <= 3'h0;
      else if (ce && boot_r != 3'h7) boot_r <= boot_r + 3'h1;
   end
   wire logic take_w = ce && boot_r == 3'h7;
   wire logic known_w = req.cmd inside {8'h37, 8'h38, 8'h39, 8'h40, 8'h41};
   property p_read_answer;
      take_w && req.rd && !req.wr && known_w |=> rsp.rvalid && !rsp.nack;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read unanswered");
   property p_unknown_nack;
      take_w && (req.rd || req.wr) && !known_w && req.cmd != 8'h03 |=> rsp.nack && !rsp.rvalid;
   endproperty
   a_unknown_nack: assert property (p_unknown_nack) else $error("unknown not refused");
   property p_answer_cause;
      rsp.rvalid |-> $past(req.rd && ce);
   endproperty
   a_answer_cause: assert property (p_answer_cause) else $error("stray rvalid");
   property p_phase1; phase1_slot == ((phase0_slot + 5'h08) & 5'h0f); endproperty
   a_phase1: assert property (p_phase1) else $error("second phase misplaced");
   property p_phase_range; phase0_slot < 5'h10; endproperty
   a_phase_range: assert property (p_phase_range) else $error("slot not wrapped");
   property p_alert; alert_line_n == !ov_fault; endproperty
   a_alert: assert property (p_alert) else $error("alert mismatch");
   property p_sticky;
      ov_fault && !(ce && req.wr && req.cmd == 8'h03) |=> ov_fault;
   endproperty
   a_sticky: assert property (p_sticky) else $error("fault dropped");
   property p_off_hold; output_off |=> output_off; endproperty
   a_off_hold: assert property (p_off_hold) else $error("restart seen");
   property p_reset_vals;
      $fell(rst) |-> gain_fields == 16'hb2ae && offset_fields == 16'hbd00;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad cal reset");
   c_read: cover property (take_w && req.rd ##1 rsp.rvalid);
   c_nack: cover property (rsp.nack);
   c_fault: cover property ($rose(ov_fault));
endmodule // cal_regs_properties
bind cal_regs cal_regs_properties u_props (.clk, .rst, .ce, .req, .rsp, .phase0_slot,
   .phase1_slot, .alert_line_n, .ov_fault, .output_off, .gain_fields, .offset_fields);
`default_nettype wire

//--- verif/vout_model.sv
// partner: output voltage reading seen by the overvoltage comparator
`timescale 1ns/10ps
`default_nettype none
module vout_model
(
   input  wire logic        clk,
   input  wire logic [15:0] level,
   input  wire logic        output_off,
   output logic [15:0]      vout_code
);
   initial vout_code = 16'h0000;
   // a shut-down output collapses, so the reading falls to zero
   always @(posedge clk)
   begin
      vout_code <= output_off ? 16'h0000 : level;
   end
endmodule // vout_model
`default_nettype wire

//--- verif/cal_regs_tb.sv
// testbench: defaults, phase placement, calibration fields and overvoltage handling
`timescale 1ns/10ps
`default_nettype none
module cal_regs_tb;
   logic                    clk, rst, ce, share_auto_en, alert_line_n, ov_fault, output_off;
   cal_regs_pkg::host_req_t req;
   cal_regs_pkg::host_rsp_t rsp;
   logic [15:0]             level, vout_code, cfg_strap, v_strap;
   logic [4:0]              share_auto_slot, phase0_slot, phase1_slot;
   cal_regs_pkg::lin11_t    gain_fields, offset_fields;
   int                      fails, checks;
   logic [7:0]              ph [7] = '{8'h32, 8'h11, 8'h01, 8'h00, 8'h53, 8'h72, 8'h43};
   // first straps: count 3 position 2, one volt selected
   cal_regs dut (.clk, .rst, .ce, .req, .rsp, .cfg_strap,
      .voltage_select_strap(v_strap), .vout_code, .share_auto_en, .share_auto_slot,
      .phase0_slot, .phase1_slot, .alert_line_n, .ov_fault, .output_off, .gain_fields,
      .offset_fields);
   vout_model pm (.clk, .level, .output_off, .vout_code);
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one request cycle; the answer stands only in the cycle after it is taken
   task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d);
      @(posedge clk) req <= '{wr: w, rd: !w, cmd: c, wdata: d};
      @(posedge clk) req <= '0;
      #1;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      acc(1'b1, c, d);
      check({rsp.rvalid, rsp.nack}, 2'b00);
   endtask
   task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
      acc(1'b0, c, 16'h0000);
      check({rsp.rvalid, rsp.nack}, 2'b10);
      check(rsp.rdata, exp);
   endtask
   function automatic logic [4:0] slot_of(input logic [7:0] v);
      int n;
      int p;
      int s;
      n = (v[7:4] == 4'h0) ? 16 : int'(v[7:4]);
      p = (v[3:0] == 4'h0) ? 16 : int'(v[3:0]);
      s = (32 * p + n) / (2 * n);   // round half up
      return (s >= 16) ? 5'(s - 16) : 5'(s);
   endfunction
   task automatic test_done;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
      begin
         $display("ALL CHECKS OK");
      end
      else
      begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // watchdog: the sequence needs a few microseconds
   initial
   begin
      #20000;
      fails++;
      test_done;
   end
   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      req = '0;
      level = 16'h1000;
      cfg_strap = 16'h0032;
      v_strap = 16'h2000;
      share_auto_en = 1'b0;
      share_auto_slot = 5'h05;
      fails = 0;
      checks = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      tick(8);
      rd_chk(8'h37, 16'h0032);
      rd_chk(8'h38, 16'hb2ae);
      rd_chk(8'h39, 16'hbd00);
      rd_chk(8'h40, 16'h2330);
      rd_chk(8'h41, 16'h0080);
      // zero fields, rounding and wrap; unused upper byte must read zero
      foreach (ph[i])
      begin
         wr(8'h37, {8'hff, ph[i]});
         tick(3);
         rd_chk(8'h37, {8'h00, ph[i]});
         check(phase0_slot, slot_of(ph[i]));
         check(phase1_slot, (slot_of(ph[i]) + 5'h08) & 5'h0f);
      end
      @(posedge clk) share_auto_en <= 1'b1;
      tick(5);
      check(phase0_slot, 5'h05);
      check(phase1_slot, 5'h0d);
      @(posedge clk) share_auto_en <= 1'b0;
      wr(8'h38, 16'h0bff);
      wr(8'h39, 16'hf401);
      tick(1);
      check(gain_fields, 16'h0bff);
      check(offset_fields, 16'hf401);
      rd_chk(8'h38, 16'h0bff);
      acc(1'b0, 8'h55, 16'h0000);
      check({rsp.rvalid, rsp.nack}, 2'b01);
      check(rsp.rdata, 16'h0000);
      wr(8'h40, 16'hffae);
      rd_chk(8'h40, 16'hffae);
      // at the threshold nothing trips; one code above trips and shuts down
      wr(8'h40, 16'h2000);
      @(posedge clk) level <= 16'h2000;
      tick(8);
      check({ov_fault, alert_line_n, output_off}, 3'b010);
      @(posedge clk) level <= 16'h2001;
      tick(8);
      check({ov_fault, alert_line_n, output_off}, 3'b101);
      wr(8'h03, 16'h0000);
      tick(8);
      check({ov_fault, alert_line_n, output_off}, 3'b011);
      // mid-run reset with new straps; a request during the strap load is ignored
      @(posedge clk)
      begin
         rst       <= 1'b1;
         level     <= 16'h1000;
         cfg_strap <= 16'h1243;
         v_strap   <= 16'h1000;
      end
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      tick(1);
      check({ov_fault, alert_line_n, output_off}, 3'b010);
      acc(1'b0, 8'h38, 16'h0000);
      check({rsp.rvalid, rsp.nack}, 2'b00);
      tick(4);
      rd_chk(8'h37, 16'h0043);
      rd_chk(8'h38, 16'hb2ae);
      rd_chk(8'h40, 16'h1198);
      check(phase0_slot, 5'h0c);
      // clock enable low: a write is not taken and the answer stays idle
      @(posedge clk) ce <= 1'b0;
      acc(1'b1, 8'h38, 16'h1234);
      check({rsp.rvalid, rsp.nack}, 2'b00);
      @(posedge clk) ce <= 1'b1;
      rd_chk(8'h38, 16'hb2ae);
      test_done;
   end
endmodule // cal_regs_tb
`default_nettype wire
